// ==== afespi_port.v ====
// serial configuration port of the dual channel sensor front end
// Overview of operation
// - first gain one bit (250/42), second gain two bits (4,8,16,32)
// - first gain bit set selects the low gain mode of stage one
// - filter route bit zero feeds stages direct, one via filter pins
// - filter route bit lives in configuration register, serially writable
// - common mode select bit picks 1.15V or 2.59V
// - three wire port, writes only after reset, reads once unlocked
// - chip select release aborts an unfinished transaction, no partial write
// - chip select assertion restarts bit counter and state
// - chip select may be tied low; framing then by bit count
// - write is one command byte then one data byte
// - incoming data sampled on rising serial clock edges
// - on reads, drive data pin after falling edge ending bit eight
// - read data bits change on falling clock edges
// - release data pin after sixteenth rising edge or chip select high
// - turnaround between master release and device drive is half cycle
// - read mode persists over any number of reads until unlock rewritten
// - input and output share one bidirectional data pin
// - command: bit7 read flag, bits 6:4 zero, bits 3:0 address
// - unlock by writing fe then ed; any other write to the unlock address leaves read mode
// - config at 0 reset 00, offset code at 1 reset 80, unlock at f
// - config bits: channel 7, power 6:5, filter 4, mode 3, gains 2:1 0
`include "afespi_defs.vh"
module afespi_port (
    mclk,
    sys_rst,
    serial_clk,
    chip_select_low,
    serial_data_in,
    serial_data_out,
    serial_data_oe_n,
    input_channel_select,
    amp_power_enable,
    external_filter_route,
    common_mode_select,
    second_stage_gain_select,
    first_stage_gain_select,
    offset_dac_code,
    read_mode,
    nonzero_reserved_seen
);
    input wire mclk;
    input wire sys_rst;
    input wire serial_clk;
    input wire chip_select_low;
    input wire serial_data_in;
    output reg serial_data_out;
    output reg serial_data_oe_n;
    output reg input_channel_select;
    output reg [1:0] amp_power_enable;
    output reg external_filter_route;
    output reg common_mode_select;
    output reg [1:0] second_stage_gain_select;
    output reg first_stage_gain_select;
    output reg [7:0] offset_dac_code;
    output reg read_mode;
    output reg nonzero_reserved_seen;

    // frame phase states, one-hot
    localparam ST_CMD = 3'b001;
    localparam ST_WDATA = 3'b010;
    localparam ST_RDATA = 3'b100;

    wire sclk_s;
    wire csn_s;
    wire din_s;
    reg sclk_d_ff;
    reg csn_d_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [4:0] bitcnt_ff;
    reg [4:0] nxt_bitcnt;
    reg [7:0] cmd_ff;
    reg [7:0] nxt_cmd;
    reg [7:0] data_ff;
    reg [7:0] nxt_data;
    reg [7:0] cfg_ff;
    reg [7:0] nxt_cfg;
    reg [7:0] dac_ff;
    reg [7:0] nxt_dac;
    reg key1_ff;
    reg nxt_key1;
    reg rmode_ff;
    reg nxt_rmode;
    reg [7:0] shout_ff;
    reg [7:0] nxt_shout;
    reg oe_n_ff;
    reg nxt_oe_n;
    reg rsv_ff;
    reg nxt_rsv;
    reg [7:0] wbyte;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_active;

    // register read mux by address
    function [7:0] afespi_rd;
        input [3:0] addr;
        input [7:0] cfg;
        input [7:0] dac;
        begin
            case (addr)
                `AFESPI_ADDR_CFG: afespi_rd = cfg;
                `AFESPI_ADDR_DAC: afespi_rd = dac;
                default: afespi_rd = 8'h00;
            endcase
        end
    endfunction

    // pins into the mclk domain
    afespi_sync #(.RST_VAL(1'b1)) u_sclk_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(serial_clk),
        .dout(sclk_s)
    );
    afespi_sync #(.RST_VAL(1'b1)) u_csn_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(chip_select_low),
        .dout(csn_s)
    );
    afespi_sync #(.RST_VAL(1'b0)) u_din_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(serial_data_in),
        .dout(din_s)
    );

    // edge finders on synchronised pins
    always @(posedge mclk) begin
        if (sys_rst) begin
            sclk_d_ff <= 1'b1;
            csn_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            csn_d_ff <= csn_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d_ff;
    assign sclk_fall = ~sclk_s & sclk_d_ff;
    assign cs_fall = ~csn_s & csn_d_ff;
    assign cs_active = ~csn_s;

    // frame sequencing, decode and register update
    always @* begin
        nxt_state = state_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_cmd = cmd_ff;
        nxt_data = data_ff;
        nxt_cfg = cfg_ff;
        nxt_dac = dac_ff;
        nxt_key1 = key1_ff;
        nxt_rmode = rmode_ff;
        nxt_shout = shout_ff;
        nxt_oe_n = oe_n_ff;
        nxt_rsv = rsv_ff;
        wbyte = {data_ff[6:0], din_s};
        if (!cs_active || cs_fall) begin
            // abort on release, restart on assertion
            nxt_state = ST_CMD;
            nxt_bitcnt = 5'd0;
            nxt_oe_n = 1'b1;
        end else begin
            case (state_ff)
                ST_CMD: begin
                    if (sclk_rise) begin
                        nxt_cmd = {cmd_ff[6:0], din_s};
                        nxt_bitcnt = bitcnt_ff + 5'd1;
                        if (bitcnt_ff == `AFESPI_CMD_BITS - 5'd1) begin
                            // reserved bits must be zero
                            nxt_rsv = (cmd_ff[5:3] != 3'b000);
                            if (cmd_ff[6] && rmode_ff) begin
                                nxt_state = ST_RDATA;
                                nxt_shout = afespi_rd({cmd_ff[2:0], din_s},
                                    cfg_ff, dac_ff);
                            end else begin
                                nxt_state = ST_WDATA;
                            end
                        end
                    end
                end
                ST_WDATA: begin
                    if (sclk_rise) begin
                        nxt_data = wbyte;
                        nxt_bitcnt = bitcnt_ff + 5'd1;
                        if (bitcnt_ff == `AFESPI_FRAME_BITS - 5'd1) begin
                            nxt_state = ST_CMD;
                            nxt_bitcnt = 5'd0;
                            // commit only on a full frame, writes only
                            if (!cmd_ff[`AFESPI_CMD_RW]) begin
                                case (cmd_ff[3:0])
                                    `AFESPI_ADDR_CFG: nxt_cfg = wbyte;
                                    `AFESPI_ADDR_DAC: nxt_dac = wbyte;
                                    `AFESPI_ADDR_UNLOCK: begin
                                        // two-step unlock key
                                        nxt_key1 = (wbyte ==
                                            `AFESPI_UNLOCK_KEY1);
                                        nxt_rmode = key1_ff && (wbyte ==
                                            `AFESPI_UNLOCK_KEY2);
                                    end
                                    default: nxt_cfg = cfg_ff;
                                endcase
                            end
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclk_fall && oe_n_ff &&
                        bitcnt_ff == `AFESPI_CMD_BITS) begin
                        nxt_oe_n = 1'b0;
                    end else if (sclk_fall && !oe_n_ff) begin
                        nxt_shout = {shout_ff[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        nxt_bitcnt = bitcnt_ff + 5'd1;
                        if (bitcnt_ff == `AFESPI_FRAME_BITS - 5'd1) begin
                            nxt_state = ST_CMD;
                            nxt_bitcnt = 5'd0;
                            nxt_oe_n = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_CMD;
                    nxt_bitcnt = 5'd0;
                    nxt_oe_n = 1'b1;
                end
            endcase
        end
    end

    // state and register flops
    always @(posedge mclk) begin
        if (sys_rst) begin
            state_ff <= ST_CMD;
            bitcnt_ff <= 5'd0;
            cmd_ff <= 8'h00;
            data_ff <= 8'h00;
            cfg_ff <= `AFESPI_CFG_RST;
            dac_ff <= `AFESPI_DAC_RST;
            key1_ff <= 1'b0;
            rmode_ff <= 1'b0;
            shout_ff <= 8'h00;
            oe_n_ff <= 1'b1;
            rsv_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bitcnt_ff <= nxt_bitcnt;
            cmd_ff <= nxt_cmd;
            data_ff <= nxt_data;
            cfg_ff <= nxt_cfg;
            dac_ff <= nxt_dac;
            key1_ff <= nxt_key1;
            rmode_ff <= nxt_rmode;
            shout_ff <= nxt_shout;
            oe_n_ff <= nxt_oe_n;
            rsv_ff <= nxt_rsv;
        end
    end

    // output flops, configuration fields split out
    always @(posedge mclk) begin
        if (sys_rst) begin
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1;
            input_channel_select <= 1'b0;
            amp_power_enable <= 2'b00;
            external_filter_route <= 1'b0;
            common_mode_select <= 1'b0;
            second_stage_gain_select <= 2'b00;
            first_stage_gain_select <= 1'b0;
            offset_dac_code <= `AFESPI_DAC_RST;
            read_mode <= 1'b0;
            nonzero_reserved_seen <= 1'b0;
        end else begin
            serial_data_out <= nxt_shout[7];
            serial_data_oe_n <= nxt_oe_n;
            input_channel_select <= nxt_cfg[`AFESPI_BIT_INPUT_CHANNEL_SELECT];
            amp_power_enable <=
                nxt_cfg[`AFESPI_BIT_PWR_HI:`AFESPI_BIT_PWR_LO];
            external_filter_route <= nxt_cfg[`AFESPI_BIT_FILT];
            common_mode_select <= nxt_cfg[`AFESPI_BIT_CMODE];
            second_stage_gain_select <=
                nxt_cfg[`AFESPI_BIT_G2_HI:`AFESPI_BIT_G2_LO];
            first_stage_gain_select <= nxt_cfg[`AFESPI_BIT_G1];
            offset_dac_code <= nxt_dac;
            read_mode <= nxt_rmode;
            nonzero_reserved_seen <= nxt_rsv;
        end
    end
endmodule // afespi_port

// ==== afespi_defs.vh ====
// constants for the sensor front end serial configuration port
`ifndef AFESPI_DEFS_VH
`define AFESPI_DEFS_VH
`define AFESPI_ADDR_CFG 4'h0
`define AFESPI_ADDR_DAC 4'h1
`define AFESPI_ADDR_UNLOCK 4'hf
`define AFESPI_CFG_RST 8'h00
`define AFESPI_DAC_RST 8'h80
`define AFESPI_UNLOCK_RST 8'h00
`define AFESPI_UNLOCK_KEY1 8'hfe
`define AFESPI_UNLOCK_KEY2 8'hed
`define AFESPI_BIT_INPUT_CHANNEL_SELECT 7
`define AFESPI_BIT_PWR_HI 6
`define AFESPI_BIT_PWR_LO 5
`define AFESPI_BIT_FILT 4
`define AFESPI_BIT_CMODE 3
`define AFESPI_BIT_G2_HI 2
`define AFESPI_BIT_G2_LO 1
`define AFESPI_BIT_G1 0
`define AFESPI_CMD_RW 7
`define AFESPI_FRAME_BITS 5'd16
`define AFESPI_CMD_BITS 5'd8
`endif

// ==== afespi_sync.v ====
// two flip-flop synchroniser for one pin input
module afespi_sync (
    mclk,
    sys_rst,
    din,
    dout
);
    parameter RST_VAL = 1'b0;
    input wire mclk;
    input wire sys_rst;
    input wire din;
    output wire dout;
    reg meta_ff;
    reg sync_ff;
    // first stage read only by the second
    always @(posedge mclk) begin
        if (sys_rst) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end
    assign dout = sync_ff;
endmodule // afespi_sync

// ==== afespi_master.sv ====
// partner model: spi master that drives the configuration port
module afespi_master (
    input wire logic mclk,
    input wire logic sdio,
    output logic sclk,
    output logic cs_n,
    output logic m_out,
    output logic m_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle state: clock high, deselected, line driven low
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        m_out = 1'b0;
        m_oe = 1'b1;
    end
    // one frame of n bits, msb first; tied keeps chip select low
    // read bits are taken at the rising clock edge, as a master would
    task automatic frame(input logic [7:0] cmd, dat, input int n,
        input bit tied, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, dat};
        rd = 8'h00;
        cs_n = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            m_out = sh[15 - i];
            repeat (4) @(negedge mclk);
            // sample before the device can react to this rising edge
            if (i > 7)
                rd = {rd[6:0], sdio};
            sclk = 1'b1;
            @(negedge mclk);
            if (i == 7 && cmd[7])
                m_oe = 1'b0;
            repeat (3) @(negedge mclk);
        end
        if (!tied)
            cs_n = 1'b1;
        repeat (8) @(negedge mclk);
        m_oe = 1'b1;
    endtask
endmodule // afespi_master

// ==== afespi_chk.sv ====
// assertions on the serial configuration port pins
module afespi_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serial_clk,
    input wire logic chip_select_low,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n,
    input wire logic input_channel_select,
    input wire logic [1:0] amp_power_enable,
    input wire logic external_filter_route,
    input wire logic common_mode_select,
    input wire logic [1:0] second_stage_gain_select,
    input wire logic first_stage_gain_select,
    input wire logic [7:0] offset_dac_code,
    input wire logic read_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sclk_ff;
    logic cs_ff;
    logic [4:0] cnt_ff;
    wire rise = serial_clk && !sclk_ff;
    wire [16:0] regs = {input_channel_select, amp_power_enable,
        external_filter_route, common_mode_select,
        second_stage_gain_select, first_stage_gain_select,
        offset_dac_code, read_mode};
    // pin rises in a frame, restarted by chip select fall, wraps at 16
    always @(posedge mclk) begin
        sclk_ff <= serial_clk;
        cs_ff <= chip_select_low;
        if (sys_rst || (cs_ff && !chip_select_low))
            cnt_ff <= 5'd0;
        else if (rise && !chip_select_low)
            cnt_ff <= (cnt_ff == 5'd16) ? 5'd1 : cnt_ff + 5'd1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_last_rise;
        rise && cnt_ff == 5'd15 && read_mode;
    endsequence
    sequence s_cs_up;
        $rose(chip_select_low);
    endsequence
    a_reset_values: assert property ($fell(sys_rst) |->
        regs == {8'h00, 8'h80, 1'b0} && serial_data_oe_n)
        else $error("port not at reset values");
    a_locked_quiet: assert property (!read_mode |-> serial_data_oe_n)
        else $error("pin driven while locked");
    a_cs_release: assert property (s_cs_up |->
        ##[0:6] serial_data_oe_n)
        else $error("pin held after deselect");
    a_last_release: assert property (s_last_rise |->
        ##[1:7] serial_data_oe_n)
        else $error("pin held after last rise");
    a_drive_start: assert property ($fell(serial_data_oe_n) |->
        read_mode && cnt_ff inside {5'd8, 5'd9})
        else $error("pin driven at wrong bit");
    a_bit_holds: assert property ($changed(serial_data_out) &&
        !serial_data_oe_n |=>
        ($stable(serial_data_out) || serial_data_oe_n) [*3])
        else $error("read bit changed too soon");
    a_write_frame: assert property ($changed(regs) |-> cnt_ff == 5'd16)
        else $error("register changed outside frame end");
    a_idle_quiet: assert property (chip_select_low [*8] |->
        serial_data_oe_n)
        else $error("pin driven while deselected");
endmodule // afespi_chk
bind afespi_port afespi_chk afespi_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
    .serial_clk(serial_clk), .chip_select_low(chip_select_low),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .input_channel_select(input_channel_select),
    .amp_power_enable(amp_power_enable),
    .external_filter_route(external_filter_route),
    .common_mode_select(common_mode_select),
    .second_stage_gain_select(second_stage_gain_select),
    .first_stage_gain_select(first_stage_gain_select),
    .offset_dac_code(offset_dac_code), .read_mode(read_mode));

// ==== afespi_port_test.sv ====
// self-checking bench for the serial configuration port
module afespi_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic last_ff = 1'b0;
    logic [7:0] rd;
    wire sclk, cs_n, m_out, m_oe, sdio, dout, oe_n, ics, efr, cms, g1, rm, rsv;
    wire [1:0] ape, g2;
    wire [7:0] dac, cfg;
    int bad_count = 0;
    int checked = 0;
    // shared pin; a floating line toggles so stale data never matches
    assign sdio = !oe_n ? dout : m_oe ? m_out : !last_ff;
    assign cfg = {ics, ape, efr, cms, g2, g1};
    always @(negedge mclk) last_ff <= sdio;
    afespi_master afespi_master_inst (.mclk(mclk), .sdio(sdio),
        .sclk(sclk), .cs_n(cs_n), .m_out(m_out), .m_oe(m_oe));
    afespi_port afespi_port_inst (.mclk(mclk), .sys_rst(sys_rst),
        .serial_clk(sclk), .chip_select_low(cs_n), .serial_data_in(sdio),
        .serial_data_out(dout), .serial_data_oe_n(oe_n),
        .input_channel_select(ics), .amp_power_enable(ape),
        .external_filter_route(efr), .common_mode_select(cms),
        .second_stage_gain_select(g2), .first_stage_gain_select(g1),
        .offset_dac_code(dac), .read_mode(rm), .nonzero_reserved_seen(rsv));
    // clock
    initial forever #25 mclk = ~mclk;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xf(input logic [7:0] cmd, dat, input int n = 16,
        input bit tied = 0);
        afespi_master_inst.frame(cmd, dat, n, tied, rd);
    endtask
    task automatic t_reset;
        chk("cfg", cfg, 8'h00);
        chk("dac", dac, 8'h80);
        chk("status", {6'h00, rm, oe_n}, 8'h01);
    endtask
    task automatic t_fields;
        logic [7:0] v [7] = '{8'h01, 8'h06, 8'h08, 8'h10, 8'h60, 8'h80, 8'h5a};
        foreach (v[i]) begin
            xf(8'h00, v[i]);
            chk("cfg", cfg, v[i]);
        end
        xf(8'h01, 8'h3c);
        chk("dac", dac, 8'h3c);
    endtask
    task automatic t_abort;
        xf(8'h00, 8'hff, 15);
        chk("abort", cfg, 8'h5a);
        xf(8'h00, 8'h33);
        chk("restart", cfg, 8'h33);
    endtask
    task automatic t_read;
        xf(8'h80, 8'h00);
        chk("locked", {rm, cfg[6:0]}, 8'h33);
        xf(8'h0f, 8'hed);
        xf(8'h0f, 8'hfe);
        xf(8'h0f, 8'hed);
        chk("unlock", {7'h00, rm}, 8'h01);
        xf(8'h80, 8'h00);
        chk("rd cfg", rd, 8'h33);
        xf(8'h81, 8'h00);
        chk("rd dac", rd, 8'h3c);
        xf(8'h81, 8'h00, 12);
        chk("release", {7'h00, oe_n}, 8'h01);
        xf(8'h0f, 8'h00);
        chk("relock", {7'h00, rm}, 8'h00);
    endtask
    task automatic t_rsv_tied;
        xf(8'h70, 8'h44);
        chk("rsv", {rsv, cfg[6:0]}, 8'hc4);
        xf(8'h00, 8'h21, 16, 1);
        xf(8'h01, 8'h99, 16, 1);
        chk("tied", {rsv, cfg[6:0]}, 8'h21);
        chk("tied dac", dac, 8'h99);
    endtask
    task automatic conclude;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reset, then each scenario in turn
    initial begin
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        t_reset;
        t_fields;
        t_abort;
        t_read;
        t_rsv_tied;
        conclude;
    end
endmodule // afespi_port_test
